//--- dv/lsci_props.sv
/* Checker on the pins between controller and memory.
   Instantiated by the testbench beside the joining interface. */
`timescale 1ns/1ps
module lsci_props
   import lsci_pkg::*;
#(
   parameter int INIT_WAIT = 20
) (
   input wire logic          ref_clk_i,
   input wire logic          nrst_i,
   input wire logic          cke,
   input wire logic          cs_n,
   input wire logic          ras_n,
   input wire logic          cas_n,
   input wire logic          we_n,
   input wire logic [AW-1:0] address_lines,
   input wire logic [1:0]    byte_mask_inputs,
   input wire logic          ctl_dq_oe,
   input wire logic [1:0]    mem_dq_oe
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   wire logic [3:0] pins = {cs_n, ras_n, cas_n, we_n};
   wire logic       cmd = !cs_n && pins[2:0] != 3'h7;
   logic [15:0]     cnt;
   logic            seen;
   // Saturates so a long run never wraps back under the wait
   always_ff @(posedge ref_clk_i)
      if (!nrst_i) cnt <= '0;
      else if (cnt != 16'hffff) cnt <= cnt + 16'h1;
   always_ff @(posedge ref_clk_i)
      if (!nrst_i) seen <= 1'b0;
      else if (cmd) seen <= 1'b1;

   a_init_wait: assert property (cmd |-> cnt >= INIT_WAIT - 1)
      else $error("command before power-up wait");
   a_first_pre: assert property (cmd && !seen |->
      pins == 4'h2 && address_lines[PRE_ALL_BIT])
      else $error("first command not precharge all");
   a_cmd_gap: assert property (cmd |=> (pins == 4'h7) [*3])
      else $error("command not followed by idle cycles");
   a_dq_clash: assert property (!(ctl_dq_oe && mem_dq_oe != 2'h0))
      else $error("both ends drive data lines");
   a_wr_drive: assert property ($rose(ctl_dq_oe) |-> pins == 4'h4)
      else $error("controller drives without write");
   a_drv_off: assert property (!cke [*2] |=> mem_dq_oe == 2'h0)
      else $error("memory drives with clock enable low");
   a_rd_lat: assert property (cke && $past(cke) && pins == 4'h5 &&
      byte_mask_inputs == 2'h0 |-> ##[2:3] mem_dq_oe == 2'h3)
      else $error("read data not out in latency");
   a_mask_rd: assert property (cke && byte_mask_inputs[0] |->
      ##2 !mem_dq_oe[0])
      else $error("masked low byte still driven");
   cover property (pins == 4'h5);
   cover property (pins == 4'h4);
   cover property (!cke);
   cover property (byte_mask_inputs == 2'h3);
endmodule // lsci_props

//--- dv/testbench.sv
/* Self-checking bench: controller and memory joined by lsci_if.
   Software side is an AHB-Lite master at 200 MHz. */
`timescale 1ns/1ps
module testbench;
   import lsci_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic        hready;
   logic [31:0] hrdata;
   lsci_pwr_t   pwr;
   logic        lost;
   logic [31:0] rd;
   logic [31:0] cfgv;
   logic [15:0] w [8];
   logic [1:0]  ba;
   logic [12:0] row;
   logic [12:0] col;
   logic        hresp;
   int          nref;
   integer      seed = 32'hd40fbb5d;
   int          miscompares = 0;
   int          checks = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   lsci_if u_lsci_if ();
   lsci_ctl #(.INIT_WAIT(20)) u_lsci_ctl (.ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hreadyout_o(hready), .hrdata_o(hrdata),
      .hresp_o(hresp), .pin(u_lsci_if.ctl));
   lsci_mem u_lsci_mem (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .pin(u_lsci_if.mem), .power_state_o(pwr), .data_lost_o(lost));
   lsci_props #(.INIT_WAIT(20)) u_lsci_props (.ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i), .cke(u_lsci_if.cke), .cs_n(u_lsci_if.cs_n),
      .ras_n(u_lsci_if.ras_n), .cas_n(u_lsci_if.cas_n),
      .we_n(u_lsci_if.we_n), .address_lines(u_lsci_if.address_lines),
      .byte_mask_inputs(u_lsci_if.byte_mask_inputs),
      .ctl_dq_oe(u_lsci_if.ctl_dq_oe), .mem_dq_oe(u_lsci_if.mem_dq_oe));

   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk_i);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input string s, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   function automatic logic [31:0] cmd(logic [3:0] c, logic [1:0] b,
                                       logic [12:0] a);
      return {13'h0, a, b, c};
   endfunction
   // Column of the last word of a burst from c; words were written from 0
   function automatic int last_col(int c, int k, logic il);
      int m;
      m = (1 << k) - 1;
      return il ? ((c ^ m) & m) : ((c + m) & m);
   endfunction
   // Polls until no command is pending and the controller is not busy
   task automatic idle;
      do ahb(1'b0, REG_STAT, 32'h0); while (rd[4] | rd[1]);
   endtask
   task automatic read_last(input logic [12:0] c, input logic [15:0] e);
      ahb(1'b1, REG_CMD, cmd(4'h5, ba, c));
      idle;
      ahb(1'b0, REG_RDATA, 32'h0);
      chk("rdata", {16'h0, e}, {16'h0, rd[15:0]});
   endtask
   task automatic final_report;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (50000) @(posedge ref_clk_i);
      miscompares++;
      final_report;
   end
   initial begin
      repeat (5) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      ahb(1'b0, REG_CFG, 32'h0);
      chk("cfg", 32'h60, rd);
      do ahb(1'b0, REG_STAT, 32'h0); while (rd[0] !== 1'b1);
      ahb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
      for (int k = 0; k < 4; k++) begin
         ba = 2'($random(seed));
         row = 13'($random(seed));
         // Odd start column for k above 0 (0 when k is 0) so wrap order shows in the last word
         col = 13'($random(seed) | 1) & 13'((1 << k) - 1);
         // Refresh off so the opened row survives the test
         cfgv = {25'h0, 1'b1, 1'b0, 1'b0, k[1], k[2:0]} | (k[0] << 4);
         ahb(1'b1, REG_CFG, cfgv);
         ahb(1'b1, REG_CMD, cmd(4'h2, 2'h0, 13'h0400));
         idle;
         ahb(1'b1, REG_CMD, cmd(4'h0, BA_MR,
             {6'h0, 2'h1, k[0], k[1], k[2:0]}));
         idle;
         ahb(1'b1, REG_CMD, cmd(4'h3, ba, row));
         idle;
         for (int i = 0; i < (1 << k); i++) begin
            w[i] = 16'($random(seed));
            ahb(1'b1, REG_WDATA, {16'h0, w[i]});
         end
         ahb(1'b1, REG_CMD, cmd(4'h4, ba, 13'h0));
         idle;
         read_last(col, w[last_col(col, k, k[1])]);
         $display("burst test %0d done", k);
      end
      ahb(1'b1, REG_CFG, cfgv & 32'hbf);
      repeat (4) @(posedge ref_clk_i);
      chk("power", 32'(PS_APD), {29'h0, pwr});
      chk("lost", 32'h0, {31'h0, lost});
      ahb(1'b1, REG_CFG, cfgv);
      idle;
      read_last(col, w[last_col(col, 3, 1'b1)]);
      $display("power-down test done");
      // Empty write queue: the whole burst goes out masked
      ahb(1'b1, REG_CMD, cmd(4'h4, ba, 13'h0));
      idle;
      read_last(13'h1, w[last_col(1, 3, 1'b1)]);
      $display("masked write test done");
      ahb(1'b1, REG_CFG, cfgv | 32'h20);
      nref = 0;
      repeat (REFI_CYC + 40) begin
         @(posedge ref_clk_i);
         if ({u_lsci_if.cs_n, u_lsci_if.ras_n, u_lsci_if.cas_n,
              u_lsci_if.we_n} == 4'h1) nref++;
      end
      chk("refresh", 32'h1, 32'(nref));
      $display("refresh test done");
      final_report;
   end
endmodule // testbench

//--- hw/lsci_ctl.sv
/*
 * Controller end: AHB-Lite register slave, power-up sequence, periodic
 * refresh, command issue, write-data FIFO and read capture.
 * Assumes the memory shares ref_clk_i and software paces commands.
 */
`timescale 1ns/1ps
module lsci_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input  wire logic         ref_clk_i,
   input  wire logic         nrst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int PW = $clog2(D);
   logic [W-1:0]  buf_q [D];
   logic [PW-1:0] wp;
   logic [PW-1:0] rp;
   logic [PW:0]   cnt;
   logic          push;
   logic          pop;

   assign in_ready_o = (cnt != (PW+1)'(D));
   assign out_valid_o = (cnt != '0);
   assign out_data_o = buf_q[rp];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         if (push)
            wp <= (wp == PW'(D-1)) ? '0 : wp + PW'(1);
         if (pop)
            rp <= (rp == PW'(D-1)) ? '0 : rp + PW'(1);
         cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (push)
         buf_q[wp] <= in_data_i;
   end
endmodule // lsci_fifo

module lsci_ctl
   import lsci_pkg::*;
#(
   parameter int INIT_WAIT = INIT_WAIT_CYC
) (
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic [31:0]      hrdata_o,
   output logic             hresp_o,
   lsci_if.ctl              pin
);
   typedef enum logic [2:0] {
      ST_WAIT = 3'h0, ST_PRE = 3'h1, ST_REF1 = 3'h3, ST_REF2 = 3'h2,
      ST_MRS = 3'h6, ST_EMRS = 3'h7, ST_READY = 3'h5
   } lsci_ist_t;

   lsci_ist_t     st;
   logic [17:0]   wcnt;
   logic [2:0]    gap;
   logic [10:0]   refc;
   logic          ref_due;
   logic          ref_ph;
   logic [6:0]    cfg;
   logic          cmd_pend;
   logic [18:0]   cmd_word;
   logic          ph;
   logic          ph_wr;
   logic [7:0]    ph_addr;
   logic [DW-1:0] rdata;
   logic [15:0]   rcount;
   logic [9:0]    wr_left;
   logic [9:0]    rd_left;
   logic [1:0]    rd_wait;
   logic [3:0]    op;
   logic          done;
   logic          busy;
   logic          f_in_rdy;
   logic          f_val;
   logic          f_rdy;
   logic [DW-1:0] f_data;
   lsci_cmd_t     next_op;
   logic [1:0]    next_ba;
   logic [AW-1:0] next_ad;
   logic          take_sw;
   logic          issue;

   assign {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n} = op;
   assign pin.cke = cfg[CFG_CKE];
   assign busy = wr_left != 10'h0 || rd_left != 10'h0 || rd_wait != 2'h0;
   assign done = ph && (!ph_wr || (ph_addr == REG_CMD ? !cmd_pend :
                 ph_addr == REG_WDATA ? f_in_rdy : 1'b1));

   always_comb begin
      next_op = CMD_NOP;
      next_ba = pin.bank_select_bits;
      next_ad = pin.address_lines;
      take_sw = 1'b0;
      issue = (gap == 3'h0);
      case (st)
         ST_WAIT: issue = 1'b0;
         ST_PRE: begin
            next_op = CMD_PRE;
            next_ad = AW'(1) << PRE_ALL_BIT;
         end
         ST_REF1, ST_REF2: next_op = CMD_REF;
         ST_MRS: begin
            next_op = CMD_MRS;
            next_ba = BA_MR;
            next_ad = {6'h0, cfg[CFG_CL3] ? 3'h3 : 3'h2, cfg[CFG_BT],
                       cfg[2:0]};
         end
         ST_EMRS: begin
            next_op = CMD_MRS;
            next_ba = BA_EMR;
            next_ad = '0;
         end
         ST_READY: begin
            if (ref_due && !busy) begin
               next_op = ref_ph ? CMD_REF : CMD_PRE;
               next_ad = AW'(1) << PRE_ALL_BIT;
            end else if (cmd_pend) begin
               next_op = lsci_cmd_t'(cmd_word[3:0]);
               next_ba = cmd_word[CMDF_BA_LSB +: 2];
               next_ad = cmd_word[CMDF_AD_LSB +: AW];
               take_sw = issue;
            end else begin
               issue = 1'b0;
            end
         end
         default: issue = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         st <= ST_WAIT;
         wcnt <= '0;
         gap <= 3'h0;
         op <= CMD_NOP;
         pin.bank_select_bits <= 2'h0;
         pin.address_lines <= '0;
         ref_ph <= 1'b0;
      end else begin
         op <= CMD_NOP;
         if (gap != 3'h0)
            gap <= gap - 3'h1;
         if (st == ST_WAIT) begin
            wcnt <= wcnt + 18'h1;
            if (wcnt == 18'(INIT_WAIT - 1))
               st <= ST_PRE;
         end else if (issue) begin
            op <= next_op;
            pin.bank_select_bits <= next_ba;
            pin.address_lines <= next_ad;
            gap <= 3'(GAP_CYC);
            if (st == ST_READY && ref_due && !busy)
               ref_ph <= !ref_ph;
            case (st)
               ST_PRE: st <= ST_REF1;
               ST_REF1: st <= ST_REF2;
               ST_REF2: st <= ST_MRS;
               ST_MRS: st <= ST_EMRS;
               ST_EMRS: st <= ST_READY;
               default: st <= st;
            endcase
         end
      end
   end

   // Refresh timer; an expiry in the issue cycle keeps the request
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         refc <= '0;
         ref_due <= 1'b0;
      end else begin
         if (st == ST_READY && cfg[CFG_REF_EN])
            refc <= (refc == 11'(REFI_CYC - 1)) ? '0 : refc + 11'h1;
         // Clear outside the enable: a due refresh that is switched off
         // would otherwise hold the command slot for ever
         if (st == ST_READY && cfg[CFG_REF_EN] &&
             refc == 11'(REFI_CYC - 1))
            ref_due <= 1'b1;
         else if (issue && ref_due && ref_ph && !busy)
            ref_due <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         cmd_pend <= 1'b0;
         cmd_word <= '0;
      end else if (done && ph_wr && ph_addr == REG_CMD) begin
         cmd_pend <= 1'b1;
         cmd_word <= hwdata_i[18:0];
      end else if (take_sw) begin
         cmd_pend <= 1'b0;
      end
   end

   // Write data leaves the FIFO from the command cycle on; empty masks
   assign f_rdy = (issue && next_op == CMD_WR) || wr_left != 10'h0;

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         wr_left <= 10'h0;
         pin.ctl_dq <= '0;
         pin.ctl_dq_oe <= 1'b0;
         pin.byte_mask_inputs <= 2'h0;
      end else begin
         if (issue && next_op == CMD_WR)
            wr_left <= lsci_blen(cfg[2:0]) - 10'h1;
         else if (wr_left != 10'h0)
            wr_left <= wr_left - 10'h1;
         pin.ctl_dq <= f_data;
         pin.ctl_dq_oe <= f_rdy;
         pin.byte_mask_inputs <= (f_rdy && !f_val) ? 2'h3 : 2'h0;
      end
   end

   // Capture at the read latency after the edge the memory sees
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         rd_wait <= 2'h0;
         rd_left <= 10'h0;
         rdata <= '0;
         rcount <= 16'h0;
      end else if (issue && next_op == CMD_RD) begin
         rd_wait <= cfg[CFG_CL3] ? 2'h3 : 2'h2;
         rd_left <= lsci_blen(cfg[2:0]);
      end else if (rd_wait != 2'h0) begin
         rd_wait <= rd_wait - 2'h1;
      end else if (rd_left != 10'h0) begin
         rd_left <= rd_left - 10'h1;
         rdata <= pin.data_lines;
         rcount <= rcount + 16'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ph <= 1'b0;
         ph_wr <= 1'b0;
         ph_addr <= 8'h00;
         hreadyout_o <= 1'b1;
         hrdata_o <= 32'h0;
         hresp_o <= 1'b0;
         cfg <= CFG_RESET;
      end else if (ph) begin
         if (done) begin
            ph <= 1'b0;
            hreadyout_o <= 1'b1;
            if (ph_wr && ph_addr == REG_CFG)
               cfg <= hwdata_i[6:0];
            case (ph_addr)
               REG_CMD: hrdata_o <= {13'h0, cmd_word};
               REG_RDATA: hrdata_o <= {rcount, rdata};
               REG_STAT: hrdata_o <= {27'h0, busy, f_val, ref_due,
                                      cmd_pend, st == ST_READY};
               REG_CFG: hrdata_o <= {25'h0, cfg};
               default: hrdata_o <= 32'h0;
            endcase
         end
      end else if (hsel_i && htrans_i[1] && hready_i) begin
         ph <= 1'b1;
         ph_wr <= hwrite_i;
         ph_addr <= haddr_i[7:0];
         hreadyout_o <= 1'b0;
      end
   end

   lsci_fifo #(.W(DW), .D(FIFO_DEPTH)) u_wfifo (
      .ref_clk_i   (ref_clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (done && ph_wr && ph_addr == REG_WDATA),
      .in_ready_o  (f_in_rdy),
      .in_data_i   (hwdata_i[DW-1:0]),
      .out_valid_o (f_val),
      .out_ready_i (f_rdy),
      .out_data_o  (f_data)
   );

endmodule // lsci_ctl

//--- hw/lsci_if.sv
/*
 * Pin bundle between the SDRAM controller and the memory. Resolves the
 * shared data lines from the controller's single enable and the memory's per-byte enables.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface lsci_if;
   import lsci_pkg::*;
   logic          cke;
   logic          cs_n;
   logic          ras_n;
   logic          cas_n;
   logic          we_n;
   logic [1:0]    bank_select_bits;
   logic [AW-1:0] address_lines;
   logic [1:0]    byte_mask_inputs;
   logic [DW-1:0] ctl_dq;
   logic          ctl_dq_oe;
   logic [DW-1:0] mem_dq;
   logic [1:0]    mem_dq_oe;
   logic [DW-1:0] data_lines;

   // Undriven lines read as zero
   assign data_lines[7:0] = ctl_dq_oe ? ctl_dq[7:0] :
                            mem_dq_oe[0] ? mem_dq[7:0] : 8'h00;
   assign data_lines[15:8] = ctl_dq_oe ? ctl_dq[15:8] :
                             mem_dq_oe[1] ? mem_dq[15:8] : 8'h00;

   modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank_select_bits,
                address_lines, byte_mask_inputs, data_lines,
                output mem_dq, mem_dq_oe);
   modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_select_bits,
                address_lines, byte_mask_inputs, ctl_dq, ctl_dq_oe,
                input data_lines);
endinterface

//--- hw/lsci_mem.sv
/*
 * Memory end of the low-power SDRAM command interface: command decode,
 * bank state, mode registers, bursts, read latency, byte masks and the
 * clock-enable power states. A small array stands in for the core.
 * Assumes the controller keeps the command timing between commands.
 */
`timescale 1ns/1ps
module lsci_mem
   import lsci_pkg::*;
(
   input  wire logic  ref_clk_i,
   input  wire logic  nrst_i,
   lsci_if.mem        pin,
   output lsci_pwr_t  power_state_o,
   output logic       data_lost_o
);

   logic [DW-1:0] mem [2**MEM_AW];
   lsci_pwr_t     pwr;
   logic [AW-1:0] mode;
   logic [AW-1:0] ext_mode;
   logic [3:0]    open_rows;
   logic [AW-1:0] row [4];
   logic          bact;
   logic          bwr;
   logic          bfull;
   logic [1:0]    bbank;
   logic [CW-1:0] bstart;
   logic [9:0]    bidx;
   logic [9:0]    blen;
   logic [1:0]    pv;
   logic [DW-1:0] pd [2];
   logic [1:0]    dqm_d;
   logic          lost;
   lsci_cmd_t     cmd;
   logic          run;
   logic          start;
   logic          stop;
   logic          go;
   logic          cur_wr;
   logic [1:0]    cur_bank;
   logic [CW-1:0] cur_col;
   logic [MEM_AW-1:0] cur_addr;
   logic [9:0]    next_len;
   logic          cl3;

   // Column of the idx-th word: only the low bits inside the burst move
   function automatic logic [CW-1:0] burst_col(
      input logic [CW-1:0] s, input logic [9:0] idx,
      input logic [AW-1:0] m);
      logic [CW-1:0] msk;
      logic [CW-1:0] off;
      msk = CW'(lsci_blen(m[2:0]) - 10'h001);
      if (m[MR_BT_BIT] && m[2:0] != BL_FULL)
         off = (s ^ idx[CW-1:0]) & msk;
      else
         off = (s + idx[CW-1:0]) & msk;
      burst_col = (s & ~msk) | off;
   endfunction

   // Only one row bit reaches the small array; aliasing is expected
   function automatic logic [MEM_AW-1:0] mem_addr(
      input logic [1:0] b, input logic [AW-1:0] r,
      input logic [CW-1:0] c);
      mem_addr = {b, r[0], c};
   endfunction

   always_comb begin
      cmd = lsci_decode({pin.cs_n, pin.ras_n,
                         pin.cas_n, pin.we_n});
      // Commands count only with the clock running in an active state
      run = pin.cke && (pwr == PS_RUN || pwr == PS_SUSP);
      start = run && (cmd == CMD_RD || cmd == CMD_WR);
      stop = run && (cmd == CMD_BST || cmd == CMD_PRE);
      cur_wr = start ? (cmd == CMD_WR) : bwr;
      cur_bank = start ? pin.bank_select_bits : bbank;
      cur_col = start ? pin.address_lines[CW-1:0]
                      : burst_col(bstart, bidx, mode);
      go = start || (run && bact && !stop);
      cur_addr = mem_addr(cur_bank, row[cur_bank], cur_col);
      next_len = (cmd == CMD_WR && mode[MR_WB_BIT]) ? 10'h001
                 : lsci_blen(mode[2:0]);
      cl3 = (mode[MR_CL_LSB +: 3] == 3'h3);
   end

   // Power state follows the clock enable level and the entry command
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         pwr <= PS_RUN;
      end else begin
         case (pwr)
            PS_RUN: begin
               if (!pin.cke) begin
                  if (cmd == CMD_REF)
                     pwr <= PS_SREF;
                  else if (cmd == CMD_BST)
                     pwr <= PS_DPD;
                  else if (bact || pv != 2'h0)
                     pwr <= PS_SUSP;
                  else if (open_rows != 4'h0)
                     pwr <= PS_APD;
                  else
                     pwr <= PS_PPD;
               end
            end
            default: begin
               if (pin.cke)
                  pwr <= PS_RUN;
            end
         endcase
      end
   end

   // Deep sleep drops the contents; the next mode load marks it usable
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i)
         lost <= 1'b0;
      else if (pwr == PS_RUN && !pin.cke && cmd == CMD_BST)
         lost <= 1'b1;
      else if (run && cmd == CMD_MRS)
         lost <= 1'b0;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         mode <= MR_RESET;
         ext_mode <= '0;
      end else if (run && cmd == CMD_MRS) begin
         if (pin.bank_select_bits == BA_MR)
            mode <= pin.address_lines;
         else if (pin.bank_select_bits == BA_EMR)
            ext_mode <= pin.address_lines;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         open_rows <= 4'h0;
         for (int i = 0; i < 4; i++)
            row[i] <= '0;
      end else if (run && cmd == CMD_ACT) begin
         open_rows[pin.bank_select_bits] <= 1'b1;
         row[pin.bank_select_bits] <= pin.address_lines;
      end else if (run && cmd == CMD_PRE) begin
         if (pin.address_lines[PRE_ALL_BIT])
            open_rows <= 4'h0;
         else
            open_rows[pin.bank_select_bits] <= 1'b0;
      end
   end

   // Burst engine; a new read or write cuts the running burst short
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         bact <= 1'b0;
         bwr <= 1'b0;
         bfull <= 1'b0;
         bbank <= 2'h0;
         bstart <= '0;
         bidx <= 10'h000;
         blen <= 10'h001;
      end else if (start) begin
         bact <= (next_len != 10'h001);
         bwr <= (cmd == CMD_WR);
         bfull <= (next_len == lsci_blen(BL_FULL));
         bbank <= pin.bank_select_bits;
         bstart <= pin.address_lines[CW-1:0];
         bidx <= 10'h001;
         blen <= next_len;
      end else if (stop) begin
         bact <= 1'b0;
      end else if (run && bact) begin
         bidx <= bidx + 10'h001;
         // A full page wraps until terminated
         if (!bfull && bidx + 10'h001 == blen)
            bact <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (go && cur_wr) begin
         if (!pin.byte_mask_inputs[0])
            mem[cur_addr][7:0] <= pin.data_lines[7:0];
         if (!pin.byte_mask_inputs[1])
            mem[cur_addr][15:8] <= pin.data_lines[15:8];
      end
   end

   // Read pipe: stage 0 serves latency two, stage 1 latency three.
   // Frozen while the clock enable is low so a suspended read resumes.
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         pv <= 2'h0;
         pd[0] <= '0;
         pd[1] <= '0;
         dqm_d <= 2'h0;
      end else if (pin.cke) begin
         pv[0] <= go && !cur_wr;
         pd[0] <= lost ? {DW{1'b0}} : mem[cur_addr];
         pv[1] <= pv[0];
         pd[1] <= pd[0];
         dqm_d <= pin.byte_mask_inputs;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         pin.mem_dq <= '0;
         pin.mem_dq_oe <= 2'h0;
      end else if (!pin.cke && pwr != PS_RUN) begin
         // Drivers off in every sleep state and in suspend; a suspended
         // read word comes back once the clock enable returns
         pin.mem_dq_oe <= 2'h0;
      end else if (pin.cke) begin
         pin.mem_dq <= cl3 ? pd[1] : pd[0];
         // Mask seen two edges before the data edge turns the byte off
         pin.mem_dq_oe <= {2{cl3 ? pv[1] : pv[0]}} & ~dqm_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         power_state_o <= PS_RUN;
         data_lost_o <= 1'b0;
      end else begin
         power_state_o <= pwr;
         data_lost_o <= lost;
      end
   end

endmodule // lsci_mem

//--- hw/lsci_pkg.sv
/*
 * Shared constants, types and helpers for the low-power SDRAM command
 * interface: pin encodings, mode fields, timing counts and the
 * controller's own register map. Assumes a single 200 MHz clock.
 */
package lsci_pkg;
   localparam int DW = 16;
   localparam int AW = 13;
   localparam int CW = 9;
   localparam int MEM_AW = 12;
   localparam int PRE_ALL_BIT = 10;
   // Mode register fields
   localparam int MR_BL_LSB = 0;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam int MR_WB_BIT = 9;
   localparam logic [AW-1:0] MR_RESET = 13'h0020;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [1:0] BA_MR = 2'h0;
   localparam logic [1:0] BA_EMR = 2'h2;
   // Timing
   localparam int CLK_MHZ = 200;
   localparam int REF_WINDOW_MS = 64;
   localparam int REF_COUNT = 8192;
   localparam int REFI_CYC = (REF_WINDOW_MS * 1000 * CLK_MHZ) / REF_COUNT;
   localparam int INIT_WAIT_US = 200;
   localparam int INIT_WAIT_CYC = INIT_WAIT_US * CLK_MHZ;
   localparam int GAP_CYC = 4;
   localparam int FIFO_DEPTH = 8;
   // Controller registers (byte offsets)
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_WDATA = 8'h04;
   localparam logic [7:0] REG_RDATA = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam logic [7:0] REG_CFG = 8'h10;
   localparam int CMDF_BA_LSB = 4;
   localparam int CMDF_AD_LSB = 6;
   localparam int CFG_BT = 3;
   localparam int CFG_CL3 = 4;
   localparam int CFG_REF_EN = 5;
   localparam int CFG_CKE = 6;
   localparam logic [6:0] CFG_RESET = 7'h60;

   // {cs_n, ras_n, cas_n, we_n}; DESEL stands for any cycle with cs_n high
   typedef enum logic [3:0] {
      CMD_MRS = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
      CMD_WR  = 4'h4, CMD_RD  = 4'h5, CMD_BST = 4'h6, CMD_NOP = 4'h7,
      CMD_DESEL = 4'h8
   } lsci_cmd_t;

   typedef enum logic [2:0] {
      PS_RUN = 3'h0, PS_SUSP = 3'h1, PS_APD = 3'h3, PS_PPD = 3'h2,
      PS_SREF = 3'h6, PS_DPD = 3'h7
   } lsci_pwr_t;

   function automatic lsci_cmd_t lsci_decode(input logic [3:0] s);
      lsci_decode = s[3] ? CMD_DESEL : lsci_cmd_t'({1'b0, s[2:0]});
   endfunction

   function automatic logic [9:0] lsci_blen(input logic [2:0] code);
      case (code)
         3'h0: lsci_blen = 10'h001;
         3'h1: lsci_blen = 10'h002;
         3'h2: lsci_blen = 10'h004;
         3'h3: lsci_blen = 10'h008;
         BL_FULL: lsci_blen = 10'h200;
         default: lsci_blen = 10'h001;
      endcase
   endfunction
endpackage
